// ---- hdl/dals_pkg.sv ----
// Shared constants for the dual-channel serial sample link and its controller.
// Assumes both ends run on the same 10 MHz hclk and hresetn.
package dals_pkg;
  localparam int SAMPLE_W = 14;
  localparam int LANE_BITS = 7;
  localparam logic [3:0] LAST_SLOT = 4'hd;
  localparam logic [3:0] HALF_SLOT = 4'h7;
  localparam int CFG_AW = 12;
  localparam int CFG_DW = 8;
  // Device configuration addresses and field positions.
  localparam logic [11:0] REG_DITHER = 12'h001;
  localparam logic [11:0] REG_LANE_ORDER = 12'h003;
  localparam logic [11:0] REG_WIRE_MODE = 12'h005;
  localparam logic [11:0] REG_LOW_SPEED = 12'h013;
  localparam logic [11:0] REG_POWER = 12'h015;
  localparam logic [11:0] REG_CLK_DIV = 12'h027;
  localparam logic [11:0] REG_CHOP_A = 12'h422;
  localparam logic [11:0] REG_CHOP_B = 12'h522;
  localparam logic [11:0] REG_CLK_FILT = 12'h70a;
  localparam int DITH_A_LSB = 4;
  localparam int DITH_B_LSB = 2;
  localparam logic [1:0] DITHER_OFF = 2'h3;
  localparam int LANE_ORDER_BIT = 0;
  localparam int WIRE_ONE_BIT = 0;
  localparam int PWR_CHA_BIT = 6;
  localparam int PWR_CHB_BIT = 5;
  localparam int PWR_STBY_BIT = 3;
  localparam int PWR_GLOB_BIT = 2;
  localparam int PWR_PIN_BIT = 0;
  localparam int CLK_DIV_LSB = 6;
  localparam logic [1:0] CLK_DIV_BYPASS = 2'h0;
  localparam logic [1:0] CLK_DIV_TWO = 2'h1;
  localparam int CHOP_OFF_BIT = 1;
  localparam logic CHOP_OFF_RESET = 1'b1;
  localparam int CLK_FILT_BIT = 7;
  localparam logic [3:0] SLOT_BASE_CYC = 4'h2;
  localparam logic [13:0] CHOP_SPUR = 14'h0004;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // Wake-up times.
  localparam int CLK_MHZ = 10;
  localparam int WAKE_GLOBAL_US = 85;
  localparam int WAKE_FAST_US = 55;
  localparam int WAKE_STANDBY_US = 35;
  localparam int WAKE_GLOBAL_CYC = WAKE_GLOBAL_US * CLK_MHZ;
  localparam int WAKE_FAST_CYC = WAKE_FAST_US * CLK_MHZ;
  localparam int WAKE_STANDBY_CYC = WAKE_STANDBY_US * CLK_MHZ;
  // Controller register offsets and fields.
  localparam logic [7:0] HOST_CTRL = 8'h00;
  localparam logic [7:0] HOST_CMD = 8'h04;
  localparam logic [7:0] HOST_SAMPLE_A = 8'h08;
  localparam logic [7:0] HOST_SAMPLE_B = 8'h0c;
  localparam logic [7:0] HOST_STATUS = 8'h10;
  localparam int CMD_ADDR_LSB = 8;

  typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_WAKE} dals_pwr_t;
endpackage

// ---- hdl/dals_link_if.sv ----
// Link between the converter output end and its receiving controller.
// Carries the bit clock, frame clock, four data lanes and a config write strobe.
interface dals_link_if;
  logic bit_clock_out;
  logic frame_clock_out;
  logic upper_lane_pos_a;
  logic lower_lane_pos_a;
  logic upper_lane_pos_b;
  logic lower_lane_pos_b;
  logic cfg_we;
  logic [11:0] cfg_addr;
  logic [7:0] cfg_wdata;

  modport dev (
    output bit_clock_out,
    output frame_clock_out,
    output upper_lane_pos_a,
    output lower_lane_pos_a,
    output upper_lane_pos_b,
    output lower_lane_pos_b,
    input cfg_we,
    input cfg_addr,
    input cfg_wdata
  );
  modport host (
    input bit_clock_out,
    input frame_clock_out,
    input upper_lane_pos_a,
    input lower_lane_pos_a,
    input upper_lane_pos_b,
    input lower_lane_pos_b,
    output cfg_we,
    output cfg_addr,
    output cfg_wdata
  );
endinterface

// ---- hdl/dals_device.sv ----
// Converter output end: config registers, power control and the serializer.
// Assumes cfg writes come on hclk; the power-down pin is asynchronous.
// Contract
// R1: one-wire sends fourteen bits per sample
// R2: two-wire sends seven bits per lane
// R3: one-wire uses a single lane per channel
// R4: one bit per bit-clock edge, both edges
// R5: one-wire word starts at frame rise, MSB
// R6: two-wire: upper lane MSBs, lower LSBs
// R7: two-wire frame clock is half sample rate
// R8: choose two-wire above 65 MSPS
// R9: set low-rate bits at low rates
// R10: clock divider bypass, two or four
// R11: chopper moves noise to half rate
// R12: receiver removes the half-rate spur
// R13: chopper enabled by a register write
// R14: power-down from pin or register
// R15: filter bypass shortens global wake-up
// R16: dither on by default, per-channel off
// R17: dither field 00 on, 11 off
// R18: lane order consecutive or interleaved
// R19: two-wire mode after reset
// R20: receiver frames words by frame edges
module dals_device
  import dals_pkg::*;
#(
  parameter logic [3:0] SLOT_CYC = SLOT_BASE_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [13:0] sample_a_in,
  input wire logic [13:0] sample_b_in,
  input wire logic power_down_pin,
  output logic sample_take,
  output logic dev_running,
  dals_link_if.dev lnk
);

  typedef struct packed {
    logic [1:0] dith_a;
    logic [1:0] dith_b;
    logic odd_even;
    logic one_wire_reg;
    logic [1:0] low_speed;
    logic pd_cha;
    logic pd_chb;
    logic stby_bit;
    logic glob_bit;
    logic pin_standby;
    logic [1:0] clk_div;
    logic chop_off_a;
    logic chop_off_b;
    logic filt_bypass;
    logic pin_s1;
    logic pin_s2;
    dals_pwr_t pwr;
    logic was_global;
    logic [11:0] wake_cnt;
    logic ow;
    logic il;
    logic [1:0] div;
    logic [3:0] cyc;
    logic [3:0] slot;
    logic [13:0] word_a;
    logic [13:0] word_b;
    logic [15:0] lfsr;
    logic chop_ph;
    logic bclk;
    logic frame_q;
    logic [1:0] lanes_a;
    logic [1:0] lanes_b;
    logic take;
    logic run;
  } dals_dev_state_t;

  dals_dev_state_t r;
  dals_dev_state_t n;

  // Upper lane in bit 1, lower lane in bit 0, for slot s of a fourteen-slot frame.
  function automatic logic [1:0] dals_lane_bits(input logic [13:0] w, input logic ow,
                                                input logic il, input logic [3:0] s);
    logic [3:0] j;
    logic [3:0] k;
    j = (s < HALF_SLOT) ? s : 4'(s - HALF_SLOT);
    k = 4'(j << 1);
    // R3: single lane
    if (ow)
      return {1'b0, w[4'(4'd13 - s)]};
    // R18: even/odd split
    else if (il)
      return {w[4'(4'd13 - k)], w[4'(4'd12 - k)]};
    // R6: MSBs upper
    else
      return {w[4'(4'd13 - j)], w[4'(4'd6 - j)]};
  endfunction

  function automatic logic [13:0] dals_condition(input logic [13:0] s, input logic [1:0] dith,
                                                 input logic chop_off, input logic ph,
                                                 input logic rnd);
    logic [13:0] v;
    v = s;
    // R11: alternate offset
    if (!chop_off && ph)
      v = 14'(v + CHOP_SPUR);
    // R17: only 11 stops dither
    if (dith != DITHER_OFF)
      v[0] = v[0] ^ rnd;
    return v;
  endfunction

  function automatic logic [3:0] dals_slot_len(input logic [1:0] div);
    if (div == CLK_DIV_BYPASS)
      return SLOT_CYC;
    else if (div == CLK_DIV_TWO)
      return 4'(SLOT_CYC << 1);
    else
      return 4'(SLOT_CYC << 2);
  endfunction

  always_comb
  begin
    logic pd_global;
    logic pd_stby;
    logic load;
    logic [3:0] len;
    logic [13:0] wa;
    logic [13:0] wb;
    logic [1:0] la;
    logic [1:0] lb;
    pd_global = 1'b0;
    pd_stby = 1'b0;
    load = 1'b0;
    len = 4'h0;
    wa = 14'h0000;
    wb = 14'h0000;
    la = 2'h0;
    lb = 2'h0;
    n = r;
    n.take = 1'b0;
    n.pin_s1 = power_down_pin;
    n.pin_s2 = r.pin_s1;
    if (lnk.cfg_we)
    begin
      if (lnk.cfg_addr == REG_DITHER)
      begin
        // R16: per-channel dither disable
        n.dith_a = lnk.cfg_wdata[DITH_A_LSB +: 2];
        n.dith_b = lnk.cfg_wdata[DITH_B_LSB +: 2];
      end
      else if (lnk.cfg_addr == REG_LANE_ORDER)
        n.odd_even = lnk.cfg_wdata[LANE_ORDER_BIT];
      else if (lnk.cfg_addr == REG_WIRE_MODE)
        n.one_wire_reg = lnk.cfg_wdata[WIRE_ONE_BIT];
      else if (lnk.cfg_addr == REG_LOW_SPEED)
        n.low_speed = lnk.cfg_wdata[1:0];
      else if (lnk.cfg_addr == REG_POWER)
      begin
        n.pd_cha = lnk.cfg_wdata[PWR_CHA_BIT];
        n.pd_chb = lnk.cfg_wdata[PWR_CHB_BIT];
        n.stby_bit = lnk.cfg_wdata[PWR_STBY_BIT];
        n.glob_bit = lnk.cfg_wdata[PWR_GLOB_BIT];
        n.pin_standby = lnk.cfg_wdata[PWR_PIN_BIT];
      end
      else if (lnk.cfg_addr == REG_CLK_DIV)
        n.clk_div = lnk.cfg_wdata[CLK_DIV_LSB +: 2];
      // R13: chopper by register write
      else if (lnk.cfg_addr == REG_CHOP_A)
        n.chop_off_a = lnk.cfg_wdata[CHOP_OFF_BIT];
      else if (lnk.cfg_addr == REG_CHOP_B)
        n.chop_off_b = lnk.cfg_wdata[CHOP_OFF_BIT];
      else if (lnk.cfg_addr == REG_CLK_FILT)
        n.filt_bypass = lnk.cfg_wdata[CLK_FILT_BIT];
    end
    // R14: pin role set by register
    pd_global = r.glob_bit | (r.pin_s2 & ~r.pin_standby);
    pd_stby = r.stby_bit | (r.pin_s2 & r.pin_standby);
    case (r.pwr)
      PWR_RUN:
      begin
        if (pd_global || pd_stby)
        begin
          n.pwr = PWR_DOWN;
          n.was_global = pd_global;
          n.run = 1'b0;
          n.bclk = 1'b0;
          n.frame_q = 1'b0;
          n.lanes_a = 2'h0;
          n.lanes_b = 2'h0;
        end
        else
        begin
          len = dals_slot_len(r.div);
          // R4: clock edge mid-bit
          if (r.cyc == (len >> 1))
            n.bclk = ~r.bclk;
          if (r.cyc == 4'h0)
          begin
            // R1: one word per frame
            // R7: two words per frame
            load = (r.slot == 4'h0) || (!r.ow && r.slot == HALF_SLOT);
            wa = r.word_a;
            wb = r.word_b;
            if (load)
            begin
              wa = dals_condition(sample_a_in, r.dith_a, r.chop_off_a, r.chop_ph, r.lfsr[0]);
              wb = dals_condition(sample_b_in, r.dith_b, r.chop_off_b, r.chop_ph, r.lfsr[1]);
              n.word_a = wa;
              n.word_b = wb;
              n.take = 1'b1;
              n.chop_ph = ~r.chop_ph;
              n.lfsr = {r.lfsr[14:0], r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};
            end
            // R5: frame rises with MSB
            n.frame_q = (r.slot < HALF_SLOT);
            // R2: seven slots per lane word
            la = dals_lane_bits(wa, r.ow, r.il, r.slot);
            lb = dals_lane_bits(wb, r.ow, r.il, r.slot);
            n.lanes_a = r.pd_cha ? 2'h0 : la;
            n.lanes_b = r.pd_chb ? 2'h0 : lb;
          end
          if (r.cyc == 4'(len - 4'h1))
          begin
            n.cyc = 4'h0;
            if (r.slot == LAST_SLOT)
            begin
              n.slot = 4'h0;
              // Mode changes only at a frame edge so no word is torn.
              n.ow = r.one_wire_reg;
              n.il = r.odd_even;
              // R10: divider sets bit time
              n.div = r.clk_div;
            end
            else
              n.slot = 4'(r.slot + 4'h1);
          end
          else
            n.cyc = 4'(r.cyc + 4'h1);
        end
      end
      PWR_DOWN:
      begin
        n.was_global = r.was_global | pd_global;
        if (!pd_global && !pd_stby)
        begin
          n.pwr = PWR_WAKE;
          // R15: faster wake with bypass
          if (!r.was_global)
            n.wake_cnt = 12'(WAKE_STANDBY_CYC);
          else if (r.filt_bypass)
            n.wake_cnt = 12'(WAKE_FAST_CYC);
          else
            n.wake_cnt = 12'(WAKE_GLOBAL_CYC);
        end
      end
      PWR_WAKE:
      begin
        if (pd_global || pd_stby)
        begin
          n.pwr = PWR_DOWN;
          n.was_global = pd_global;
        end
        else if (r.wake_cnt == 12'h001)
        begin
          n.pwr = PWR_RUN;
          n.run = 1'b1;
          n.cyc = 4'h0;
          n.slot = 4'h0;
          n.ow = r.one_wire_reg;
          n.il = r.odd_even;
          n.div = r.clk_div;
        end
        else
          n.wake_cnt = 12'(r.wake_cnt - 12'h001);
      end
      default:
        n.pwr = PWR_DOWN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // R19: two-wire after reset
      r <= '0;
      r.pwr <= PWR_RUN;
      r.run <= 1'b1;
      r.chop_off_a <= CHOP_OFF_RESET;
      r.chop_off_b <= CHOP_OFF_RESET;
      r.lfsr <= LFSR_SEED;
    end
    else
      r <= n;
  end

  assign lnk.bit_clock_out = r.bclk;
  assign lnk.frame_clock_out = r.frame_q;
  assign lnk.upper_lane_pos_a = r.lanes_a[1];
  assign lnk.lower_lane_pos_a = r.lanes_a[0];
  assign lnk.upper_lane_pos_b = r.lanes_b[1];
  assign lnk.lower_lane_pos_b = r.lanes_b[0];
  assign sample_take = r.take;
  assign dev_running = r.run;
endmodule

// ---- hdl/dals_host.sv ----
// Receiving controller: AHB-Lite register slave, config writer and deserializer.
// Assumes the link signals are asynchronous to hclk and are synchronised here.
module dals_host
  import dals_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [13:0] sample_a_out,
  output logic [13:0] sample_b_out,
  output logic sample_valid,
  dals_link_if.host lnk
);

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic bclk_d;
    logic frame_d;
    logic aligned;
    logic [3:0] cnt;
    logic [13:0] wa;
    logic [13:0] wb;
    logic [13:0] prev_a;
    logic [13:0] prev_b;
    logic [13:0] out_a;
    logic [13:0] out_b;
    logic valid;
    logic ow;
    logic il;
    logic chop_rm;
    logic [19:0] cmd;
    logic cfg_we;
    logic [11:0] cfg_addr;
    logic [7:0] cfg_data;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [15:0] words;
  } dals_host_state_t;

  dals_host_state_t r;
  dals_host_state_t n;

  function automatic logic [13:0] dals_place(input logic [13:0] w, input logic [3:0] j,
                                             input logic up, input logic lo,
                                             input logic ow, input logic il);
    logic [13:0] v;
    logic [3:0] k;
    v = w;
    k = 4'(j << 1);
    if (ow)
      v[4'(4'd13 - j)] = lo;
    else if (il)
    begin
      v[4'(4'd13 - k)] = up;
      v[4'(4'd12 - k)] = lo;
    end
    else
    begin
      v[4'(4'd13 - j)] = up;
      v[4'(4'd6 - j)] = lo;
    end
    return v;
  endfunction

  // Averaging two neighbours nulls the half-rate spur at the cost of bandwidth.
  function automatic logic [13:0] dals_avg(input logic [13:0] a, input logic [13:0] b);
    logic [14:0] s;
    s = 15'(a) + 15'(b);
    return s[14:1];
  endfunction

  always_comb
  begin
    logic start;
    logic f;
    logic [3:0] j;
    logic [13:0] wa;
    logic [13:0] wb;
    start = 1'b0;
    f = 1'b0;
    j = 4'h0;
    wa = 14'h0000;
    wb = 14'h0000;
    n = r;
    n.valid = 1'b0;
    n.cfg_we = 1'b0;
    n.s1 = {lnk.bit_clock_out, lnk.frame_clock_out, lnk.upper_lane_pos_a,
            lnk.lower_lane_pos_a, lnk.upper_lane_pos_b, lnk.lower_lane_pos_b};
    n.s2 = r.s1;
    n.bclk_d = r.s2[5];
    // R4: capture on both edges
    if (r.s2[5] != r.bclk_d)
    begin
      f = r.s2[4];
      n.frame_d = f;
      // R20: frame edge marks word
      start = r.ow ? (f && !r.frame_d) : (f != r.frame_d);
      j = start ? 4'h0 : r.cnt;
      wa = dals_place(start ? 14'h0000 : r.wa, j, r.s2[3], r.s2[2], r.ow, r.il);
      wb = dals_place(start ? 14'h0000 : r.wb, j, r.s2[1], r.s2[0], r.ow, r.il);
      n.wa = wa;
      n.wb = wb;
      n.cnt = 4'(j + 4'h1);
      n.aligned = r.aligned | start;
      if ((r.aligned || start) && j == (r.ow ? LAST_SLOT : 4'h6))
      begin
        // R12: notch the chopper spur
        n.out_a = r.chop_rm ? dals_avg(wa, r.prev_a) : wa;
        n.out_b = r.chop_rm ? dals_avg(wb, r.prev_b) : wb;
        n.prev_a = wa;
        n.prev_b = wb;
        n.valid = 1'b1;
        n.words = 16'(r.words + 16'h0001);
      end
    end
    if (r.wr_pend)
    begin
      n.wr_pend = 1'b0;
      if (r.wr_addr == HOST_CTRL)
        n.chop_rm = hwdata[0];
      else if (r.wr_addr == HOST_CMD)
      begin
        n.cmd = hwdata[19:0];
        n.cfg_we = 1'b1;
        n.cfg_addr = hwdata[CMD_ADDR_LSB +: CFG_AW];
        n.cfg_data = hwdata[CFG_DW - 1:0];
        // The deserializer follows the mode it has itself commanded.
        if (hwdata[CMD_ADDR_LSB +: CFG_AW] == REG_WIRE_MODE)
          n.ow = hwdata[WIRE_ONE_BIT];
        else if (hwdata[CMD_ADDR_LSB +: CFG_AW] == REG_LANE_ORDER)
          n.il = hwdata[LANE_ORDER_BIT];
      end
    end
    if (hsel && htrans[1] && hready)
    begin
      n.wr_pend = hwrite;
      n.wr_addr = haddr[7:0];
      if (hwrite)
        n.rdata = 32'h0000_0000;
      else if (haddr[7:0] == HOST_CTRL)
        n.rdata = {31'h0000_0000, r.chop_rm};
      else if (haddr[7:0] == HOST_CMD)
        n.rdata = {12'h000, r.cmd};
      else if (haddr[7:0] == HOST_SAMPLE_A)
        n.rdata = {18'h0_0000, r.out_a};
      else if (haddr[7:0] == HOST_SAMPLE_B)
        n.rdata = {18'h0_0000, r.out_b};
      else if (haddr[7:0] == HOST_STATUS)
        n.rdata = {r.words, 14'h0000, r.il, r.ow};
      else
        n.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= n;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign sample_a_out = r.out_a;
  assign sample_b_out = r.out_b;
  assign sample_valid = r.valid;
  assign lnk.cfg_we = r.cfg_we;
  assign lnk.cfg_addr = r.cfg_addr;
  assign lnk.cfg_wdata = r.cfg_data;
endmodule

// ---- tb/dals_link_properties.sv ----
// Checker on the link between converter end and receiving controller.
// Assumes every link signal is sampled on hclk and cleared by hresetn.
module dals_link_properties
  import dals_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bit_clock_out,
  input wire logic frame_clock_out,
  input wire logic upper_lane_pos_a,
  input wire logic lower_lane_pos_a,
  input wire logic upper_lane_pos_b,
  input wire logic lower_lane_pos_b,
  input wire logic cfg_we,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Power-down drives every output low; the escape keeps frames cut short legal.
  wire quiet = !(bit_clock_out | frame_clock_out | upper_lane_pos_a | lower_lane_pos_a
    | upper_lane_pos_b | lower_lane_pos_b);
  wire [3:0] lanes = {upper_lane_pos_a, lower_lane_pos_a, upper_lane_pos_b, lower_lane_pos_b};
  logic one_wire_reg;
  logic [1:0] frames_reg;
  // Mode applies only from a later frame, so three frame rises are awaited.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      one_wire_reg <= 1'b0;
      frames_reg <= 2'h0;
    end
    else if (cfg_we && cfg_addr == REG_WIRE_MODE)
    begin
      one_wire_reg <= cfg_wdata[WIRE_ONE_BIT];
      frames_reg <= 2'h0;
    end
    else if ($rose(frame_clock_out) && frames_reg != 2'h3)
      frames_reg <= frames_reg + 2'h1;
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_high_half;
    (frame_clock_out || quiet) [*8];
  endsequence
  sequence s_next_frame;
    (!$rose(frame_clock_out)) [*8] ##[1:120] ($rose(frame_clock_out) || quiet);
  endsequence
  property p_frame_high;
    $rose(frame_clock_out) |-> s_high_half;
  endproperty
  a_frame_high: assert property (p_frame_high)
    else $error("frame clock high phase too short");
  property p_frame_low;
    $fell(frame_clock_out) |=> (!frame_clock_out) [*7];
  endproperty
  a_frame_low: assert property (p_frame_low)
    else $error("frame clock low phase too short");
  property p_frame_len;
    $rose(frame_clock_out) |=> s_next_frame;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length out of range");
  property p_bclk_ddr;
    $changed(bit_clock_out) |=> $stable(bit_clock_out) || quiet;
  endproperty
  a_bclk_ddr: assert property (p_bclk_ddr)
    else $error("bit clock toggled on consecutive cycles");
  property p_data_mid;
    $changed(lanes) |-> $stable(bit_clock_out) || quiet;
  endproperty
  a_data_mid: assert property (p_data_mid)
    else $error("lane changed together with bit clock");
  property p_bclk_runs;
    !quiet |-> ##[1:8] ($changed(bit_clock_out) || quiet);
  endproperty
  a_bclk_runs: assert property (p_bclk_runs)
    else $error("bit clock stopped while running");
  property p_one_wire;
    one_wire_reg && frames_reg == 2'h3 |-> !upper_lane_pos_a && !upper_lane_pos_b;
  endproperty
  a_one_wire: assert property (p_one_wire)
    else $error("upper lane active in one-wire mode");
  property p_cfg_pulse;
    cfg_we |=> !cfg_we;
  endproperty
  a_cfg_pulse: assert property (p_cfg_pulse)
    else $error("config strobe longer than one cycle");
endmodule

// ---- tb/dual_adc_lvds_serializer_tb_top.sv ----
// Testbench: AHB-Lite master on the controller, which drives the converter end.
// Assumes the controller forwards CMD writes over the link and deserializes it.
module dual_adc_lvds_serializer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dals_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pin = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic hreadyout, hresp, sample_take, dev_running, sample_valid;
  logic [13:0] sa = 14'h1e35, sb = 14'h2c93, ra, rb, s1, s2;
  int num_errors = 0, n_compared = 0, cyc = 0, n, diffs;
  int ord_tab[5] = '{0, 1, 0, 0, 1};
  int wire_tab[5] = '{0, 0, 1, 1, 0};
  int div_tab[5] = '{0, 0, 0, 1, 2};
  always #50 hclk = ~hclk;
  dals_link_if lnk();
  dals_device u_dals_device (.hclk(hclk), .hresetn(hresetn), .sample_a_in(sa),
    .sample_b_in(sb), .power_down_pin(pin), .sample_take(sample_take),
    .dev_running(dev_running), .lnk(lnk.dev));
  dals_host u_dals_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample_a_out(ra),
    .sample_b_out(rb), .sample_valid(sample_valid), .lnk(lnk.host));
  dals_link_properties u_props (.hclk(hclk), .hresetn(hresetn),
    .bit_clock_out(lnk.bit_clock_out), .frame_clock_out(lnk.frame_clock_out),
    .upper_lane_pos_a(lnk.upper_lane_pos_a), .lower_lane_pos_a(lnk.lower_lane_pos_a),
    .upper_lane_pos_b(lnk.upper_lane_pos_b), .lower_lane_pos_b(lnk.lower_lane_pos_b),
    .cfg_we(lnk.cfg_we), .cfg_addr(lnk.cfg_addr), .cfg_wdata(lnk.cfg_wdata));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmd(input logic [11:0] a, input logic [7:0] d);
    ahb(1'b1, HOST_CMD, {12'h000, a, d});
    repeat (4) @(posedge hclk);
  endtask
  task automatic wait_valid(input int k);
    repeat (k)
    begin
      @(posedge hclk);
      while (sample_valid !== 1'b1) @(posedge hclk);
    end
  endtask
  task automatic rise(input bit fr);
    if (fr)
      @(posedge lnk.frame_clock_out);
    else
      @(posedge sample_take);
  endtask
  task automatic period(input bit fr, output int p);
    time t0;
    rise(fr);
    t0 = $time;
    rise(fr);
    p = int'(($time - t0) / 100);
  endtask
  // Releasing by pin is counted from the pin, by register from the end of the command task, four cycles after the write.
  task automatic wake(input logic [7:0] down, input bit use_pin, input int exp);
    cmd(REG_POWER, down);
    pin <= use_pin;
    repeat (20) @(posedge hclk);
    check("down_running", 32'(dev_running), 32'h0000_0000);
    check("down_link", 32'(lnk.frame_clock_out | lnk.bit_clock_out), 32'h0000_0000);
    if (use_pin)
      pin <= 1'b0;
    else
      cmd(REG_POWER, 8'h00);
    n = 0;
    while (dev_running !== 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
    check("wake_time", 32'(n >= exp - 8 && n <= exp + 8), 32'h0000_0001);
  endtask
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      num_errors++;
      $display("MISMATCH timeout expected done seen hang");
      give_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, HOST_STATUS, 32'h0000_0000);
    check("status_reset", {30'h0, rd[1:0]}, 32'h0000_0000);
    ahb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped", rd, 32'h0000_0000);
    check("resp_okay", 32'(hresp), 32'h0000_0000);
    ahb(1'b1, HOST_CTRL, 32'h0000_0001);
    ahb(1'b0, HOST_CTRL, 32'h0000_0000);
    check("ctrl_rw", rd, 32'h0000_0001);
    ahb(1'b1, HOST_CTRL, 32'h0000_0000);
    wait_valid(2);
    diffs = 0;
    repeat (16)
    begin
      wait_valid(1);
      check("dither_msbs", 32'(ra[13:1]), 32'(sa[13:1]));
      diffs += int'(ra[0] !== sa[0]);
    end
    check("dither_on", 32'(diffs != 0), 32'h0000_0001);
    cmd(REG_DITHER, {2'h0, DITHER_OFF, DITHER_OFF, 2'h0});
    for (int i = 0; i < 5; i++)
    begin
      sa <= 14'h1e35 ^ 14'(i);
      sb <= 14'h2c93 ^ 14'(i << 9);
      cmd(REG_LANE_ORDER, 8'(ord_tab[i]));
      cmd(REG_WIRE_MODE, 8'(wire_tab[i]));
      cmd(REG_CLK_DIV, 8'(div_tab[i] << CLK_DIV_LSB));
      wait_valid(4);
      check("word_a", 32'(ra), 32'(sa));
      check("word_b", 32'(rb), 32'(sb));
      period(1'b1, n);
      check("frame_period", 32'(n), 32'(14 * (int'(SLOT_BASE_CYC) << div_tab[i])));
      period(1'b0, n);
      check("sample_period", 32'(n),
        32'((wire_tab[i] + 1) * 7 * (int'(SLOT_BASE_CYC) << div_tab[i])));
      ahb(1'b0, HOST_STATUS, 32'h0000_0000);
      check("status_mode", {30'h0, rd[1:0]}, 32'(ord_tab[i] * 2 + wire_tab[i]));
    end
    ahb(1'b0, HOST_SAMPLE_A, 32'h0000_0000);
    check("sample_reg", rd, {18'h0, sa});
    ahb(1'b0, HOST_SAMPLE_B, 32'h0000_0000);
    check("sample_reg_b", rd, {18'h0, sb});
    ahb(1'b0, HOST_CMD, 32'h0000_0000);
    check("cmd_readback", rd, {12'h000, REG_CLK_DIV, 8'h80});
    cmd(REG_LOW_SPEED, 8'h03);
    cmd(REG_CHOP_A, 8'h00);
    cmd(REG_CHOP_B, 8'h00);
    wait_valid(3);
    s1 = ra;
    s2 = rb;
    wait_valid(1);
    check("chop_pair", 32'(s1 ^ ra), 32'(sa ^ (sa + CHOP_SPUR)));
    check("chop_pair_b", 32'(s2 ^ rb), 32'(sb ^ (sb + CHOP_SPUR)));
    // With removal on, a chopped pair reads back as its midpoint.
    ahb(1'b1, HOST_CTRL, 32'h0000_0001);
    wait_valid(3);
    check("spur_removed", 32'(ra), 32'(sa + (CHOP_SPUR >> 1)));
    ahb(1'b1, HOST_CTRL, 32'h0000_0000);
    cmd(REG_CHOP_A, 8'h02);
    cmd(REG_CHOP_B, 8'h02);
    wake(8'h04, 1'b0, WAKE_GLOBAL_CYC);
    wake(8'h00, 1'b1, WAKE_GLOBAL_CYC);
    wake(8'h01, 1'b1, WAKE_STANDBY_CYC);
    wake(8'h08, 1'b0, WAKE_STANDBY_CYC);
    cmd(REG_CLK_FILT, 8'h80);
    wake(8'h04, 1'b0, WAKE_FAST_CYC);
    cmd(REG_POWER, 8'h40);
    wait_valid(4);
    check("chan_a_off", 32'(ra), 32'h0000_0000);
    check("chan_b_on", 32'(rb), 32'(sb));
    cmd(REG_POWER, 8'h20);
    wait_valid(4);
    check("chan_a_on", 32'(ra), 32'(sa));
    check("chan_b_off", 32'(rb), 32'h0000_0000);
    give_verdict();
  end
endmodule
